// ### hw/sfa_consts.vh
// Purpose: Constants for the storage fetch adapter serial flash master.
// Assumes: Included by the adapter design file only.
// Notes:   Instruction codes, sequence defaults and field widths.
`ifndef SFA_CONSTS_VH
`define SFA_CONSTS_VH
`define SFA_CMD_WREN      8'h06
`define SFA_CMD_WVCR      8'h81
`define SFA_VCR_DATA      8'h8b
`define SFA_CMD_EN4B      8'hb7
`define SFA_CMD_FREAD     8'h0b
`define SFA_DUMMY_BYTES   3'h1
`define SFA_LAST_BIT      4'h7
`define SFA_ADDR_W        32
`define SFA_LEN_W         16
`define SFA_DEF_LARGE     1'h0
`endif

// ### hw/sfa_storage_fetch_adapter.v
// Purpose: Fixed-function serial flash read master for the storage fetch adapter.
// Assumes: One clock, synchronous high reset, single flash device on the bus.
// Notes:   Serial clock is the input clock divided by two (mode 0).
//          Requests are refused until setup ends and while a frame is open.
//          Dummy and address byte counts are fixed when the block is built.
`timescale 1ns/10ps
`default_nettype none
`include "sfa_consts.vh"
module sfa_storage_fetch_adapter #(
    parameter [0:0] correction_enable_param     = 1'h1,
    parameter [0:0] classification_enable_param = 1'h1,
    parameter [0:0] large_storage_param         = `SFA_DEF_LARGE,
    parameter [0:0] issue_write_enable_param    = large_storage_param,
    parameter [0:0] issue_volatile_cfg_param    = large_storage_param,
    parameter [0:0] issue_four_byte_entry_param = large_storage_param
) (
    input  wire                    clk,
    input  wire                    sys_rst,
    input  wire                    clk_en,
    input  wire                    fetch_req,
    input  wire [`SFA_ADDR_W-1:0]  fetch_addr,
    input  wire [`SFA_LEN_W-1:0]   fetch_len,
    output reg                     fetch_busy_r,
    output reg                     setup_done_r,
    output reg                     fetch_data_valid_r,
    output reg  [7:0]              fetch_data_r,
    output reg                     fetch_done_r,
    output reg                     spi_sclk_r,
    output reg                     spi_cs_n_r,
    output reg                     spi_mosi_r,
    input  wire                    spi_miso
);
    // The port is only active when a function needs external storage.
    // With both functions off the engine is held in reset, select high and clock low.
    localparam [0:0] PORT_ON = correction_enable_param | classification_enable_param;

    // Top-level sequencer states.
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_WREN1 = 4'h1;
    localparam [3:0] ST_VCR   = 4'h2;
    localparam [3:0] ST_WREN2 = 4'h3;
    localparam [3:0] ST_EN4B  = 4'h4;
    localparam [3:0] ST_READY = 4'h5;
    localparam [3:0] ST_CMD   = 4'h6;
    localparam [3:0] ST_ADDR  = 4'h7;
    localparam [3:0] ST_DUMMY = 4'h8;
    localparam [3:0] ST_DATA  = 4'h9;
    localparam [3:0] ST_GAP   = 4'ha;

    // Byte engine: shift one byte with divided clock and report its end.
    reg  [3:0]             state_r;
    reg  [3:0]             after_gap_r;
    // Shift registers and bit position of the byte in flight.
    reg  [7:0]             tx_r;
    reg  [7:0]             rx_r;
    reg  [3:0]             bit_cnt_r;
    reg                    byte_act_r;
    reg                    byte_end_r;
    // Byte counters, setup progress and the latched request.
    reg  [2:0]             cnt_r;
    reg                    vcr_data_sent_r;
    reg                    four_byte_r;
    reg  [`SFA_ADDR_W-1:0] addr_r;
    reg  [`SFA_LEN_W-1:0]  left_r;

    // Picks the address byte to send, most significant first.
    function [7:0] addr_byte;
        input [`SFA_ADDR_W-1:0] a;
        input [2:0]             idx;
        begin
            case (idx)
                3'h3:    addr_byte = a[31:24];
                3'h2:    addr_byte = a[23:16];
                3'h1:    addr_byte = a[15:8];
                default: addr_byte = a[7:0];
            endcase
        end
    endfunction

    // Starts a new byte on the serial link.
    task start_byte;
        input [7:0] b;
        begin
            tx_r       <= b;
            spi_mosi_r <= b[7];
            bit_cnt_r  <= 4'h0;
            byte_act_r <= 1'h1;
            spi_cs_n_r <= 1'h0;
        end
    endtask

    // Closes the frame and moves to a state after an idle gap.
    // The gap keeps each instruction in a chip-select frame of its own.
    task end_frame;
        input [3:0] nxt;
        begin
            spi_cs_n_r  <= 1'h1;
            after_gap_r <= nxt;
            state_r     <= ST_GAP;
        end
    endtask

    // Serial shifter: sclk toggles each enabled cycle while a byte is active, half period one clock.
    // The flash launches each bit after the falling clock, so the bit is taken as the clock rises.
    // A byte ends on the edge that returns the serial clock low after its eighth bit.
    always @(posedge clk) begin
        if (sys_rst || !PORT_ON) begin
            spi_sclk_r <= 1'h0;
            rx_r       <= 8'h00;
            byte_end_r <= 1'h0;
        end else if (clk_en) begin
            byte_end_r <= 1'h0;
            if (byte_act_r) begin
                spi_sclk_r <= ~spi_sclk_r;
                if (!spi_sclk_r) begin
                    rx_r <= {rx_r[6:0], spi_miso};
                end else if (bit_cnt_r == `SFA_LAST_BIT) begin
                    byte_end_r <= 1'h1;
                end
            end
        end
    end

    // Sequencer for setup frames and fast read frames.
    // Reset leaves select high, the clock low and every request flag clear.
    always @(posedge clk) begin
        if (sys_rst || !PORT_ON) begin
            state_r            <= ST_IDLE;
            after_gap_r        <= ST_IDLE;
            tx_r               <= 8'h00;
            bit_cnt_r          <= 4'h0;
            byte_act_r         <= 1'h0;
            cnt_r              <= 3'h0;
            vcr_data_sent_r    <= 1'h0;
            four_byte_r        <= 1'h0;
            addr_r             <= {`SFA_ADDR_W{1'b0}};
            left_r             <= {`SFA_LEN_W{1'b0}};
            fetch_busy_r       <= 1'h0;
            setup_done_r       <= 1'h0;
            fetch_data_valid_r <= 1'h0;
            fetch_data_r       <= 8'h00;
            fetch_done_r       <= 1'h0;
            spi_cs_n_r         <= 1'h1;
            spi_mosi_r         <= 1'h0;
        end else if (clk_en) begin
            fetch_data_valid_r <= 1'h0;
            fetch_done_r       <= 1'h0;
            // Advance one bit after each falling edge of the serial clock.
            // The last bit is held until the engine drops, so no ninth shift occurs.
            if (byte_act_r && spi_sclk_r) begin
                if (bit_cnt_r == `SFA_LAST_BIT) begin
                    byte_act_r <= 1'h0;
                end else begin
                    bit_cnt_r  <= bit_cnt_r + 4'h1;
                    tx_r       <= {tx_r[6:0], 1'b0};
                    spi_mosi_r <= tx_r[6];
                end
            end
            case (state_r)
                // Pick the first setup frame from the build-time options.
                ST_IDLE: begin
                    fetch_busy_r <= 1'h1;
                    if (issue_volatile_cfg_param) begin
                        state_r <= issue_write_enable_param ? ST_WREN1 : ST_VCR;
                    end else if (issue_four_byte_entry_param) begin
                        state_r <= issue_write_enable_param ? ST_WREN2 : ST_EN4B;
                    end else begin
                        state_r <= ST_READY;
                    end
                    start_byte(issue_volatile_cfg_param ?
                               (issue_write_enable_param ? `SFA_CMD_WREN : `SFA_CMD_WVCR) :
                               (issue_write_enable_param ? `SFA_CMD_WREN : `SFA_CMD_EN4B));
                    // With no setup frames the byte just started is cancelled at once.
                    if (!issue_volatile_cfg_param && !issue_four_byte_entry_param) begin
                        byte_act_r <= 1'h0;
                        spi_cs_n_r <= 1'h1;
                    end
                end
                // Write enable ahead of the configuration write.
                ST_WREN1: begin
                    if (byte_end_r) begin
                        end_frame(ST_VCR);
                    end
                end
                // Configuration write, instruction then data byte.
                ST_VCR: begin
                    if (byte_end_r) begin
                        // The data byte follows the instruction inside the same frame.
                        if (!vcr_data_sent_r) begin
                            vcr_data_sent_r <= 1'h1;
                            start_byte(`SFA_VCR_DATA);
                        end else begin
                            end_frame(issue_four_byte_entry_param ?
                                      (issue_write_enable_param ? ST_WREN2 : ST_EN4B) : ST_READY);
                        end
                    end
                end
                // Write enable ahead of the four-byte entry.
                ST_WREN2: begin
                    if (byte_end_r) begin
                        end_frame(ST_EN4B);
                    end
                end
                // Four-byte entry; later reads carry four address bytes.
                ST_EN4B: begin
                    if (byte_end_r) begin
                        four_byte_r <= 1'h1;
                        end_frame(ST_READY);
                    end
                end
                ST_GAP: begin
                    // One idle cycle with select high, then open the next setup frame, or return to ready with select left high.
                    state_r <= after_gap_r;
                    case (after_gap_r)
                        ST_VCR:   start_byte(`SFA_CMD_WVCR);
                        ST_WREN2: start_byte(`SFA_CMD_WREN);
                        ST_EN4B:  start_byte(`SFA_CMD_EN4B);
                        default:  spi_cs_n_r <= 1'h1;
                    endcase
                end
                // Wait for a request; zero-length requests are ignored.
                ST_READY: begin
                    setup_done_r <= 1'h1;
                    fetch_busy_r <= 1'h0;
                    // A request during a frame never reaches this state, so it is dropped.
                    if (fetch_req && fetch_len != {`SFA_LEN_W{1'b0}}) begin
                        fetch_busy_r <= 1'h1;
                        addr_r       <= fetch_addr;
                        left_r       <= fetch_len;
                        state_r      <= ST_CMD;
                        start_byte(`SFA_CMD_FREAD);
                    end
                end
                // Fast read instruction, then the top address byte.
                ST_CMD: begin
                    if (byte_end_r) begin
                        // The count holds the address bytes still to send after the first.
                        cnt_r   <= four_byte_r ? 3'h3 : 3'h2;
                        state_r <= ST_ADDR;
                        start_byte(addr_byte(addr_r, four_byte_r ? 3'h3 : 3'h2));
                    end
                end
                // Remaining address bytes, then the dummy byte once the count is spent.
                ST_ADDR: begin
                    if (byte_end_r) begin
                        if (cnt_r == 3'h0) begin
                            cnt_r   <= `SFA_DUMMY_BYTES;
                            state_r <= ST_DUMMY;
                            start_byte(8'h00);
                        end else begin
                            cnt_r <= cnt_r - 3'h1;
                            start_byte(addr_byte(addr_r, cnt_r - 3'h1));
                        end
                    end
                end
                // Dummy bytes of eight clocks each, counted down.
                ST_DUMMY: begin
                    if (byte_end_r) begin
                        if (cnt_r == 3'h1) begin
                            state_r <= ST_DATA;
                            start_byte(8'h00);
                        end else begin
                            cnt_r <= cnt_r - 3'h1;
                            start_byte(8'h00);
                        end
                    end
                end
                // Data bytes; the last one closes the frame with the done pulse.
                ST_DATA: begin
                    if (byte_end_r) begin
                        fetch_data_r       <= rx_r;
                        fetch_data_valid_r <= 1'h1;
                        left_r             <= left_r - {{(`SFA_LEN_W-1){1'b0}}, 1'b1};
                        if (left_r == {{(`SFA_LEN_W-1){1'b0}}, 1'b1}) begin
                            fetch_done_r <= 1'h1;
                            end_frame(ST_READY);
                        end else begin
                            start_byte(8'h00);
                        end
                    end
                end
                // An unused code restarts the setup sequence.
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### sim/sfa_fetch_chk.sv
// Purpose: Port checks for the serial flash master.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Bound onto every adapter instance.
`timescale 1ns/10ps
`default_nettype none
module sfa_fetch_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic fetch_req,
    input wire logic fetch_busy_r,
    input wire logic setup_done_r,
    input wire logic fetch_data_valid_r,
    input wire logic fetch_done_r,
    input wire logic spi_sclk_r,
    input wire logic spi_cs_n_r,
    input wire logic spi_mosi_r
);
    // Every check runs on clk and rests during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_sclk_idle; spi_cs_n_r |-> !spi_sclk_r; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high outside frame");
    property p_sclk_half; clk_en && spi_sclk_r |=> !spi_sclk_r; endproperty
    a_sclk_half: assert property (p_sclk_half) else $error("sclk high too long");
    property p_mosi_hold; spi_sclk_r |-> $stable(spi_mosi_r); endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");
    property p_rd_op; $fell(spi_cs_n_r) && setup_done_r |-> !spi_mosi_r; endproperty
    a_rd_op: assert property (p_rd_op) else $error("read opcode first bit wrong");
    property p_valid_pulse; clk_en && fetch_data_valid_r |=> !fetch_data_valid_r; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
    property p_done_valid; fetch_done_r |-> fetch_data_valid_r; endproperty
    a_done_valid: assert property (p_done_valid) else $error("done without byte");
    property p_busy_req; $rose(fetch_busy_r) && setup_done_r |-> $past(fetch_req && clk_en); endproperty
    a_busy_req: assert property (p_busy_req) else $error("busy without request");
    property p_cs_gap; $rose(spi_cs_n_r) |-> !spi_sclk_r && $past(!spi_sclk_r); endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("frame closed with serial clock high");
endmodule
bind sfa_storage_fetch_adapter sfa_fetch_chk sfa_fetch_chk_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .fetch_req(fetch_req), .fetch_busy_r(fetch_busy_r), .setup_done_r(setup_done_r),
    .fetch_data_valid_r(fetch_data_valid_r), .fetch_done_r(fetch_done_r), .spi_sclk_r(spi_sclk_r),
    .spi_cs_n_r(spi_cs_n_r), .spi_mosi_r(spi_mosi_r));
`default_nettype wire

// ### sim/sfa_flash_model.sv
// Purpose: Behavioural serial flash answering fast reads.
// Assumes: Mode 0 serial clock, one byte of dummy clocks.
// Notes:   Data byte is a weighted sum of address bytes plus offset.
`timescale 1ns/10ps
`default_nettype none
module sfa_flash_model (
    input wire logic spi_sclk_r,
    input wire logic spi_cs_n_r,
    input wire logic spi_mosi_r,
    output var logic spi_miso
);
    logic [7:0] sr, op, b1, db;
    logic [31:0] addr;
    logic four_r = 1'b0;
    int bits, idx;
    logic [15:0] log_q[$];
    initial spi_miso = 1'b1;
    // A new frame clears the byte counters.
    always @(negedge spi_cs_n_r) begin
        bits = 0;
        idx = 0;
        b1 = 8'h00;
        addr = 32'h0;
    end
    // Shift in on the rising clock and decode whole bytes.
    always @(posedge spi_sclk_r) if (!spi_cs_n_r) begin
        sr = {sr[6:0], spi_mosi_r};
        bits++;
        if (bits == 8) begin
            bits = 0;
            if (idx == 0) op = sr;
            if (idx == 1) b1 = sr;
            if (idx >= 1 && idx <= (four_r ? 4 : 3)) addr = {addr[23:0], sr};
            idx++;
        end
    end
    // Data goes out after the falling clock; otherwise the line keeps changing.
    always @(negedge spi_sclk_r) begin
        db = 8'(addr[31:24] * 3 + addr[23:16] * 5 + addr[15:8] * 7 + addr[7:0] + idx - (four_r ? 4 : 3) - 2);
        if (!spi_cs_n_r && op == 8'h0b && idx >= (four_r ? 4 : 3) + 2) spi_miso <= db[7 - bits];
        else spi_miso <= ~spi_miso;
    end
    // Frame end logs opcode and first operand and applies mode changes.
    always @(posedge spi_cs_n_r) begin
        if (idx > 0) log_q.push_back({op, b1});
        if (idx > 0 && op == 8'hb7) four_r = 1'b1;
        spi_miso <= ~spi_miso;
    end
endmodule
`default_nettype wire

// ### sim/sfa_storage_fetch_adapter_tb.sv
// Purpose: Self-checking bench for the serial flash master.
// Assumes: All three setup options on, four-byte addressing.
// Notes:   Random reads plus busy, pause and zero-length corners; a second adapter uses small defaults.
`timescale 1ns/10ps
`default_nettype none
module sfa_storage_fetch_adapter_tb;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, fetch_req = 1'b0;
    logic [31:0] fetch_addr = 32'h0;
    logic [15:0] fetch_len = 16'h0;
    logic fetch_busy_r, setup_done_r, fetch_data_valid_r, fetch_done_r, spi_sclk_r, spi_cs_n_r, spi_mosi_r, spi_miso;
    logic [7:0] fetch_data_r;
    logic sm_req = 1'b0, sm_busy, sm_setup, sm_valid, sm_done, sm_sclk, sm_cs_n, sm_mosi, sm_miso;
    logic [7:0] sm_data;
    int bad_count = 0, checked = 0, cyc = 0;
    logic [15:0] exp_setup [4] = '{16'h0600, 16'h818b, 16'h0600, 16'hb700};
    sfa_storage_fetch_adapter #(.large_storage_param(1'h1)) sfa_storage_fetch_adapter_inst (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_len(fetch_len), .fetch_busy_r(fetch_busy_r), .setup_done_r(setup_done_r),
        .fetch_data_valid_r(fetch_data_valid_r), .fetch_data_r(fetch_data_r), .fetch_done_r(fetch_done_r),
        .spi_sclk_r(spi_sclk_r), .spi_cs_n_r(spi_cs_n_r), .spi_mosi_r(spi_mosi_r), .spi_miso(spi_miso));
    sfa_flash_model sfa_flash_model_inst (.spi_sclk_r(spi_sclk_r), .spi_cs_n_r(spi_cs_n_r),
        .spi_mosi_r(spi_mosi_r), .spi_miso(spi_miso));
    // Second adapter on the small-flash defaults: no setup frames, three address bytes.
    if (1) begin : g_small
        sfa_storage_fetch_adapter sfa_storage_fetch_adapter_inst (
            .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .fetch_req(sm_req), .fetch_addr(fetch_addr),
            .fetch_len(fetch_len), .fetch_busy_r(sm_busy), .setup_done_r(sm_setup),
            .fetch_data_valid_r(sm_valid), .fetch_data_r(sm_data), .fetch_done_r(sm_done),
            .spi_sclk_r(sm_sclk), .spi_cs_n_r(sm_cs_n), .spi_mosi_r(sm_mosi), .spi_miso(sm_miso));
        sfa_flash_model sfa_flash_model_inst (.spi_sclk_r(sm_sclk), .spi_cs_n_r(sm_cs_n),
            .spi_mosi_r(sm_mosi), .spi_miso(sm_miso));
    end
    // Clock and hang guard.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    // Expected byte for a given address and offset.
    function automatic logic [7:0] exp_byte(input logic [31:0] a, input int k);
        return 8'(a[31:24] * 3 + a[23:16] * 5 + a[15:8] * 7 + a[7:0] + k);
    endfunction
    // Compare and count.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic complete_run();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One read; odd also repeats the request while busy and pauses the clock enable.
    task automatic do_read(input logic [31:0] a, input logic [15:0] n, input logic odd);
        int k, t, sz;
        k = 0;
        t = 0;
        sz = sfa_flash_model_inst.log_q.size();
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        fetch_len <= n;
        @(posedge clk);
        fetch_req <= odd;
        fetch_addr <= ~a;
        @(posedge clk);
        fetch_req <= 1'b0;
        clk_en <= !odd;
        repeat (5) @(posedge clk);
        clk_en <= 1'b1;
        while (k < n && t < 3000) begin
            @(posedge clk);
            t++;
            if (fetch_data_valid_r === 1'b1) begin
                chk(fetch_data_r, exp_byte(a, k), "read byte");
                chk(fetch_done_r, k == n - 1, "done flag");
                k++;
            end
        end
        while (fetch_busy_r !== 1'b0 && t < 3000) begin
            @(posedge clk);
            t++;
        end
        chk(k, n, "byte count");
        chk(sfa_flash_model_inst.log_q.size(), sz + 1, "read frames");
        chk(sfa_flash_model_inst.log_q[sz][15:8], 8'h0b, "read opcode");
    endtask
    // Main sequence.
    initial begin
        int i, k, t;
        logic [31:0] a;
        void'($urandom(69669));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        while (setup_done_r !== 1'b1 && cyc < 5000) @(posedge clk);
        chk(sfa_flash_model_inst.log_q.size(), 4, "setup frame count");
        for (i = 0; i < 4; i++) chk(sfa_flash_model_inst.log_q[i], exp_setup[i], "setup frame");
        do_read(32'hffffffff, 16'h1, 1'b1);
        do_read(32'h00000000, 16'h3, 1'b0);
        for (i = 0; i < 8; i++) do_read($urandom, 16'(1 + $urandom % 5), 1'b0);
        // Small-flash adapter: no setup frames, three address bytes, two data bytes.
        a = $urandom;
        k = 0;
        t = 0;
        chk(sm_setup, 1'b1, "short setup done");
        chk(g_small.sfa_flash_model_inst.log_q.size(), 0, "short setup frames");
        @(posedge clk);
        sm_req <= 1'b1;
        fetch_addr <= a;
        fetch_len <= 16'h2;
        @(posedge clk);
        sm_req <= 1'b0;
        while (k < 2 && t < 3000) begin
            @(posedge clk);
            t++;
            if (sm_valid === 1'b1) begin
                chk(sm_data, exp_byte({8'h00, a[23:0]}, k), "short read byte");
                chk(sm_done, k == 1, "short done flag");
                k++;
            end
        end
        repeat (2) @(posedge clk);
        chk(sm_busy, 1'b0, "short busy");
        chk(k, 2, "short byte count");
        chk(g_small.sfa_flash_model_inst.log_q.size(), 1, "short read frames");
        chk(g_small.sfa_flash_model_inst.log_q[0][15:8], 8'h0b, "short read opcode");
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_len <= 16'h0;
        repeat (4) @(posedge clk);
        fetch_req <= 1'b0;
        chk(fetch_busy_r, 1'b0, "zero length taken");
        complete_run();
    end
endmodule
`default_nettype wire
